// *** hdl/led_ctrl_pkg.sv ***
package led_ctrl_pkg;
   // Serial port device address, seven bits
   localparam logic [6:0] DEV_ADDR      = 7'h1B;
   // Data register indices carried by the index byte
   localparam logic [1:0] IDX_MAIN      = 2'h0;
   localparam logic [1:0] IDX_CAMERA    = 2'h1;
   localparam logic [1:0] IDX_AUX_CTL   = 2'h2;
   // Camera byte fields
   localparam int         CAM_HI_LSB    = 4;
   localparam int         CAM_LO_LSB    = 0;
   // Auxiliary/control byte fields
   localparam int         AUX_LVL_LSB   = 0;
   localparam int         CTL_SER_SEL   = 2;
   localparam int         CTL_SER_HI    = 3;
   localparam int         CTL_GPO_MODE  = 4;
   localparam int         CTL_GPO_LEVEL = 5;
   // Bit counter landmarks
   localparam logic [3:0] BIT_LAST      = 4'h7;
   localparam logic [3:0] BIT_ACK       = 4'h8;
   localparam logic [3:0] BIT_ACK_DONE  = 4'h9;
   // Values after reset or under-voltage
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [3:0] RST_NIB       = 4'h0;
   localparam logic [1:0] RST_AUX       = 2'h0;
   // Pump mode codes
   localparam logic [1:0] PUMP_1X       = 2'h0;
   localparam logic [1:0] PUMP_1P5X     = 2'h1;
   localparam logic [1:0] PUMP_2X       = 2'h2;
   // Synchronised input lanes
   localparam int         SYNC_N        = 4;
   localparam int         LANE_SCL      = 0;
   localparam int         LANE_SDA      = 1;
   localparam int         LANE_CAM      = 2;
   localparam int         LANE_DROP     = 3;
   typedef enum logic [2:0] {st_idle, st_addr, st_index, st_data, st_skip} port_state_e;
endpackage : led_ctrl_pkg

// *** hdl/in_sync.sv ***
module in_sync
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic clk_en,
   // Asynchronous level in, clean level out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_ff;

   // Second stage is the only reader of the first
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_ff  <= 1'b0;
         sync_out <= 1'b0;
      end
      else if (clk_en)
      begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : in_sync

// *** hdl/led_brightness_control_regs.sv ***
// What this block does
// - Hold eight-bit main brightness code, 256 levels, shared by all main outputs.
// - Main brightness zero disables every main output.
// - Hold two-bit auxiliary code, four levels, written over the serial port.
// - Auxiliary output may act as general purpose output set by writes.
// - Digital supply under-voltage forces all registers to zero.
// - Two four-bit camera registers, high and low level, 16 steps each.
// - Active camera register chosen by serial setting or by select pin.
// - Active camera code zero disables all camera outputs.
// - Select pin high uses high register, low uses low register.
// - Select pin falling edge returns pump mode to 1x.
// - One serial data bit is shifted in per serial clock.
// - Dropout steps pump 1x to 1.5x, later dropout to 2x.
// - Any brightness update over the serial port returns pump to 1x.
// - Bytes arrive most significant bit first, sampled on rising clock.
// - Stop after a data write pulses load, copying all registers at once.
module led_brightness_control_regs
(
   // Clock, reset, enable
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   // Supply monitor, high while digital supply is good
   input  wire logic       digital_supply_ok,
   // Serial port pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // Camera select pin and dropout indication
   input  wire logic       camera_level_select,
   input  wire logic       dropout_i,
   // Converter codes and enables
   output logic [7:0]      main_level,
   output logic            main_enable,
   output logic [3:0]      camera_level,
   output logic            camera_enable,
   output logic [1:0]      aux_level,
   output logic            aux_gpo,
   // Pump mode and load strobe
   output logic [1:0]      pump_output,
   output logic            load_strobe
);
   logic [led_ctrl_pkg::SYNC_N-1:0] raw_in;
   logic [led_ctrl_pkg::SYNC_N-1:0] syn_in;
   logic [led_ctrl_pkg::SYNC_N-1:0] prev_ff;
   logic                            uv_clr;
   logic                            scl_rise;
   logic                            scl_fall;
   logic                            start_det;
   logic                            stop_det;
   logic                            drop_rise;
   logic                            cam_fall;
   logic                            ok_sync;
   logic [7:0]                      byte_in;
   led_ctrl_pkg::port_state_e       state_ff;
   logic [3:0]                      bit_cnt_ff;
   logic [7:0]                      shift_ff;
   logic                            ack_pend_ff;
   logic [1:0]                      index_ff;
   logic                            wrote_ff;
   logic [7:0]                      main_sh_ff;
   logic [7:0]                      cam_sh_ff;
   logic [7:0]                      ctl_sh_ff;
   logic [7:0]                      main_dac_ff;
   logic [7:0]                      cam_dac_ff;
   logic [7:0]                      ctl_dac_ff;
   logic [3:0]                      nxt_cam;

   function automatic logic nonzero(input logic [7:0] v);
      nonzero = (v != led_ctrl_pkg::RST_BYTE);
   endfunction : nonzero

   assign raw_in[led_ctrl_pkg::LANE_SCL]  = scl_i;
   assign raw_in[led_ctrl_pkg::LANE_SDA]  = sda_i;
   assign raw_in[led_ctrl_pkg::LANE_CAM]  = camera_level_select;
   assign raw_in[led_ctrl_pkg::LANE_DROP] = dropout_i;

   genvar gi;
   generate
      for (gi = 0; gi < led_ctrl_pkg::SYNC_N; gi++)
      begin : g_sync
         in_sync u_sync
         (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .clk_en   (clk_en),
            .async_in (raw_in[gi]),
            .sync_out (syn_in[gi])
         );
      end
   endgenerate

   in_sync u_supply
   (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .async_in (digital_supply_ok),
      .sync_out (ok_sync)
   );

   assign uv_clr = !ok_sync;

   // Edges are taken from the clean copies only
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_ff <= '0;
      else if (clk_en)
         prev_ff <= syn_in;
   end

   assign scl_rise  = syn_in[led_ctrl_pkg::LANE_SCL] & ~prev_ff[led_ctrl_pkg::LANE_SCL];
   assign scl_fall  = ~syn_in[led_ctrl_pkg::LANE_SCL] & prev_ff[led_ctrl_pkg::LANE_SCL];
   assign start_det = syn_in[led_ctrl_pkg::LANE_SCL] & prev_ff[led_ctrl_pkg::LANE_SCL]
                      & ~syn_in[led_ctrl_pkg::LANE_SDA] & prev_ff[led_ctrl_pkg::LANE_SDA];
   assign stop_det  = syn_in[led_ctrl_pkg::LANE_SCL] & prev_ff[led_ctrl_pkg::LANE_SCL]
                      & syn_in[led_ctrl_pkg::LANE_SDA] & ~prev_ff[led_ctrl_pkg::LANE_SDA];
   assign cam_fall  = ~syn_in[led_ctrl_pkg::LANE_CAM] & prev_ff[led_ctrl_pkg::LANE_CAM];
   assign drop_rise = syn_in[led_ctrl_pkg::LANE_DROP] & ~prev_ff[led_ctrl_pkg::LANE_DROP];
   assign byte_in   = {shift_ff[6:0], syn_in[led_ctrl_pkg::LANE_SDA]};

   // Serial port framing, bit counting and acknowledge
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff    <= led_ctrl_pkg::st_idle;
         bit_cnt_ff  <= '0;
         shift_ff    <= led_ctrl_pkg::RST_BYTE;
         ack_pend_ff <= 1'b0;
         sda_oe      <= 1'b0;
         index_ff    <= '0;
      end
      else if (clk_en)
      begin
         if (uv_clr || stop_det)
         begin
            state_ff    <= led_ctrl_pkg::st_idle;
            bit_cnt_ff  <= '0;
            shift_ff    <= led_ctrl_pkg::RST_BYTE;
            ack_pend_ff <= 1'b0;
            sda_oe      <= 1'b0;
            index_ff    <= '0;
         end
         else if (start_det)
         begin
            // Repeated start restarts address phase
            state_ff    <= led_ctrl_pkg::st_addr;
            bit_cnt_ff  <= '0;
            ack_pend_ff <= 1'b0;
            sda_oe      <= 1'b0;
         end
         else if (state_ff != led_ctrl_pkg::st_idle)
         begin
            if (scl_rise)
            begin
               if (bit_cnt_ff < led_ctrl_pkg::BIT_LAST)
               begin
                  shift_ff   <= byte_in;
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end
               else if (bit_cnt_ff == led_ctrl_pkg::BIT_LAST)
               begin
                  shift_ff   <= byte_in;
                  bit_cnt_ff <= led_ctrl_pkg::BIT_ACK;
                  case (state_ff)
                     led_ctrl_pkg::st_addr:
                     begin
                        // Only writes to our address are acknowledged
                        if (byte_in[7:1] == led_ctrl_pkg::DEV_ADDR && !byte_in[0])
                        begin
                           ack_pend_ff <= 1'b1;
                           state_ff    <= led_ctrl_pkg::st_index;
                        end
                        else
                        begin
                           ack_pend_ff <= 1'b0;
                           state_ff    <= led_ctrl_pkg::st_skip;
                        end
                     end
                     led_ctrl_pkg::st_index:
                     begin
                        ack_pend_ff <= 1'b1;
                        index_ff    <= byte_in[1:0];
                        state_ff    <= led_ctrl_pkg::st_data;
                     end
                     led_ctrl_pkg::st_data:
                     begin
                        // Index walks forward so one frame can fill all registers
                        ack_pend_ff <= 1'b1;
                        index_ff    <= index_ff + 2'h1;
                     end
                     led_ctrl_pkg::st_skip:
                        ack_pend_ff <= 1'b0;
                     default:
                        ack_pend_ff <= 1'b0;
                  endcase
               end
               else if (bit_cnt_ff == led_ctrl_pkg::BIT_ACK)
                  bit_cnt_ff <= led_ctrl_pkg::BIT_ACK_DONE;
            end
            else if (scl_fall)
            begin
               if (bit_cnt_ff == led_ctrl_pkg::BIT_ACK)
                  sda_oe <= ack_pend_ff;
               else if (bit_cnt_ff == led_ctrl_pkg::BIT_ACK_DONE)
               begin
                  sda_oe     <= 1'b0;
                  bit_cnt_ff <= '0;
               end
            end
         end
      end
   end

   // Acknowledge is always a driven low
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         sda_o <= 1'b0;
      else if (clk_en)
         sda_o <= 1'b0;
   end

   // Data registers written as each data byte completes
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         main_sh_ff <= led_ctrl_pkg::RST_BYTE;
         cam_sh_ff  <= led_ctrl_pkg::RST_BYTE;
         ctl_sh_ff  <= led_ctrl_pkg::RST_BYTE;
         wrote_ff   <= 1'b0;
      end
      else if (clk_en)
      begin
         if (uv_clr)
         begin
            main_sh_ff <= led_ctrl_pkg::RST_BYTE;
            cam_sh_ff  <= led_ctrl_pkg::RST_BYTE;
            ctl_sh_ff  <= led_ctrl_pkg::RST_BYTE;
            wrote_ff   <= 1'b0;
         end
         else if (stop_det || start_det)
            wrote_ff <= wrote_ff & stop_det ? 1'b0 : wrote_ff;
         else if (scl_rise && state_ff == led_ctrl_pkg::st_data
                  && bit_cnt_ff == led_ctrl_pkg::BIT_LAST)
         begin
            wrote_ff <= 1'b1;
            case (index_ff)
               led_ctrl_pkg::IDX_MAIN:    main_sh_ff <= byte_in;
               led_ctrl_pkg::IDX_CAMERA:  cam_sh_ff  <= byte_in;
               led_ctrl_pkg::IDX_AUX_CTL: ctl_sh_ff  <= byte_in;
               default:                   wrote_ff   <= wrote_ff;
            endcase
         end
      end
   end

   // Load after stop, all converters at once
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         load_strobe <= 1'b0;
         main_dac_ff <= led_ctrl_pkg::RST_BYTE;
         cam_dac_ff  <= led_ctrl_pkg::RST_BYTE;
         ctl_dac_ff  <= led_ctrl_pkg::RST_BYTE;
      end
      else if (clk_en)
      begin
         load_strobe <= !uv_clr && stop_det && wrote_ff;
         if (uv_clr)
         begin
            main_dac_ff <= led_ctrl_pkg::RST_BYTE;
            cam_dac_ff  <= led_ctrl_pkg::RST_BYTE;
            ctl_dac_ff  <= led_ctrl_pkg::RST_BYTE;
         end
         else if (stop_det && wrote_ff)
         begin
            main_dac_ff <= main_sh_ff;
            cam_dac_ff  <= cam_sh_ff;
            ctl_dac_ff  <= ctl_sh_ff;
         end
      end
   end

   always_comb
   begin
      if (ctl_dac_ff[led_ctrl_pkg::CTL_SER_SEL])
         nxt_cam = ctl_dac_ff[led_ctrl_pkg::CTL_SER_HI] ?
                   cam_dac_ff[led_ctrl_pkg::CAM_HI_LSB +: 4] :
                   cam_dac_ff[led_ctrl_pkg::CAM_LO_LSB +: 4];
      else if (syn_in[led_ctrl_pkg::LANE_CAM])
         nxt_cam = cam_dac_ff[led_ctrl_pkg::CAM_HI_LSB +: 4];
      else
         nxt_cam = cam_dac_ff[led_ctrl_pkg::CAM_LO_LSB +: 4];
   end

   // Converter outputs, registered
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         main_level    <= led_ctrl_pkg::RST_BYTE;
         main_enable   <= 1'b0;
         camera_level  <= led_ctrl_pkg::RST_NIB;
         camera_enable <= 1'b0;
         aux_level     <= led_ctrl_pkg::RST_AUX;
         aux_gpo       <= 1'b0;
      end
      else if (clk_en)
      begin
         main_level    <= main_dac_ff;
         main_enable   <= nonzero(main_dac_ff);
         camera_level  <= nxt_cam;
         camera_enable <= nonzero({4'h0, nxt_cam});
         // General purpose mode drives full on or off
         aux_gpo       <= ctl_dac_ff[led_ctrl_pkg::CTL_GPO_MODE]
                          & ctl_dac_ff[led_ctrl_pkg::CTL_GPO_LEVEL];
         if (ctl_dac_ff[led_ctrl_pkg::CTL_GPO_MODE])
            aux_level <= {2{ctl_dac_ff[led_ctrl_pkg::CTL_GPO_LEVEL]}};
         else
            aux_level <= ctl_dac_ff[led_ctrl_pkg::AUX_LVL_LSB +: 2];
      end
   end

   // Pump mode; any return to 1x beats a dropout in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pump_output <= led_ctrl_pkg::PUMP_1X;
      else if (clk_en)
      begin
         if (uv_clr || (stop_det && wrote_ff))
            pump_output <= led_ctrl_pkg::PUMP_1X;
         else if (cam_fall)
            pump_output <= led_ctrl_pkg::PUMP_1X;
         else if (drop_rise)
         begin
            case (pump_output)
               led_ctrl_pkg::PUMP_1X:   pump_output <= led_ctrl_pkg::PUMP_1P5X;
               led_ctrl_pkg::PUMP_1P5X: pump_output <= led_ctrl_pkg::PUMP_2X;
               default:                 pump_output <= led_ctrl_pkg::PUMP_2X;
            endcase
         end
      end
   end
endmodule : led_brightness_control_regs

// *** dv/led_brightness_control_regs_assertions.sv ***
module led_ctrl_checker
(
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // Inputs watched
   input wire logic       digital_supply_ok,
   input wire logic       scl_i,
   input wire logic       sda_i,
   // Outputs watched
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic [7:0] main_level,
   input wire logic       main_enable,
   input wire logic [3:0] camera_level,
   input wire logic       camera_enable,
   input wire logic [1:0] aux_level,
   input wire logic [1:0] pump_output,
   input wire logic       load_strobe
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_MAIN_EN: assert property (main_enable == (main_level != 8'h00))
      else $error("main enable disagrees with main code");
   AST_CAM_EN: assert property (camera_enable == (camera_level != 4'h0))
      else $error("camera enable disagrees with camera code");
   AST_LOAD_PULSE: assert property (load_strobe |=> !load_strobe)
      else $error("load strobe longer than one cycle");
   AST_LOAD_STOP: assert property (load_strobe |-> scl_i && sda_i && $past(scl_i, 4) && !$past(sda_i, 6))
      else $error("load strobe without a stop");
   AST_PUMP_LOAD: assert property (load_strobe |-> ##[0:1] pump_output == led_ctrl_pkg::PUMP_1X)
      else $error("pump mode not back to 1x on load");
   AST_PUMP_STEP: assert property ($changed(pump_output) && pump_output != 2'h0 |-> pump_output == $past(pump_output) + 2'h1)
      else $error("pump mode skipped a step");
   // Sync depth plus the clear stage and the output register stage, no margin
   AST_UV_CLEAR: assert property (!digital_supply_ok [*4] |=> main_level == 8'h00 && camera_level == 4'h0 && aux_level == 2'h0 && pump_output == 2'h0)
      else $error("registers not cleared under low supply");
   AST_ACK_LEN: assert property ($rose(sda_oe) |-> sda_oe [*6] ##[1:4] !sda_oe)
      else $error("acknowledge not held for one serial clock");
   AST_SDA_LOW: assert property (sda_oe |-> !sda_o)
      else $error("data pin driven high");
endmodule : led_ctrl_checker

bind led_brightness_control_regs led_ctrl_checker u_chk (.ref_clk, .rst_n, .digital_supply_ok,
   .scl_i, .sda_i, .sda_o, .sda_oe, .main_level, .main_enable, .camera_level, .camera_enable,
   .aux_level, .pump_output, .load_strobe);

// *** dv/i2c_host_model.sv ***
module i2c_host_model
(
   // Open-drain pins, 1 means released
   output logic      scl,
   output logic      sda,
   // Resolved data wire
   input  wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus: clock stands high between frames
   initial
   begin
      scl = 1'b1;
      sda = 1'b1;
   end

   task automatic send_bit(input logic b);
      #200 sda = b;
      #200 scl = 1'b1;
      #400 scl = 1'b0;
   endtask : send_bit

   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
         send_bit(b[i]);
      #200 sda = 1'b1;
      #200 scl = 1'b1;
      #200 ack = !sda_line;
      #200 scl = 1'b0;
   endtask : send_byte

   task automatic write_frame(input logic [7:0] bytes[$], output int acks);
      logic a;
      acks = 0;
      sda = 1'b0;
      #400 scl = 1'b0;
      foreach (bytes[i])
      begin
         send_byte(bytes[i], a);
         acks = acks + int'(a);
      end
      #200 sda = 1'b0;
      #200 scl = 1'b1;
      #400 sda = 1'b1;
      #400;
   endtask : write_frame
endmodule : i2c_host_model

// *** dv/led_brightness_control_regs_test.sv ***
module led_brightness_control_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       supply_ok = 1'b1;
   logic       cam_sel = 1'b0;
   logic       dropout = 1'b0;
   logic       host_scl, host_sda, sda_o, sda_oe, main_enable, camera_enable, aux_gpo;
   logic       load_strobe;
   wire logic  sda_line;
   logic [7:0] main_level, r;
   logic [3:0] camera_level;
   logic [1:0] aux_level, pump_output;
   logic [7:0] q[$];
   logic [7:0] good;
   int         err_total = 0, checks = 0, loads = 0, cyc = 0;
   int         m_main = 0, m_hi = 0, m_lo = 0, m_ctl = 0, m_pump = 0, m_loads = 0;

   always #50 ref_clk = ~ref_clk;
   // Wired-AND data line with pull-up
   assign sda_line = host_sda & ~(sda_oe & ~sda_o);

   led_brightness_control_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
      .digital_supply_ok(supply_ok), .scl_i(host_scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe(sda_oe), .camera_level_select(cam_sel), .dropout_i(dropout),
      .main_level(main_level), .main_enable(main_enable), .camera_level(camera_level),
      .camera_enable(camera_enable), .aux_level(aux_level), .aux_gpo(aux_gpo),
      .pump_output(pump_output), .load_strobe(load_strobe));
   i2c_host_model host (.scl(host_scl), .sda(host_sda), .sda_line(sda_line));

   always @(posedge ref_clk)
   begin
      cyc++;
      if (load_strobe === 1'b1)
         loads++;
      if (cyc == 20000)
      begin
         err_total++;
         end_of_test();
      end
   end

   task end_of_test;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask : tick

   task compare_all;
      int camera_outputs;
      camera_outputs = (m_ctl[2] ? m_ctl[3] : cam_sel) ? m_hi : m_lo;
      check("main_level", main_level, 8'(m_main));
      check("main_enable", {7'h00, main_enable}, 8'(m_main != 0));
      check("camera_level", {4'h0, camera_level}, 8'(camera_outputs));
      check("camera_enable", {7'h00, camera_enable}, 8'(camera_outputs != 0));
      check("aux_level", {6'h00, aux_level}, 8'(m_ctl[4] ? 3 * m_ctl[5] : m_ctl % 4));
      check("aux_gpo", {7'h00, aux_gpo}, 8'(m_ctl[4] & m_ctl[5]));
      check("pump_output", {6'h00, pump_output}, 8'(m_pump));
   endtask : compare_all

   // Frame of address, index and n data bytes; a refused address changes nothing
   task wr(input logic [7:0] addr, input int idx, input int n, input bit zero);
      int acks;
      bit ok;
      ok = (addr === good);
      q = {addr, 8'(idx)};
      for (int k = 0; k < n; k++)
      begin
         r = zero ? 8'h00 : 8'($urandom);
         q.push_back(r);
         if (ok && idx + k == 0) m_main = int'(r);
         if (ok && idx + k == 1) m_hi = int'(r[7:4]);
         if (ok && idx + k == 1) m_lo = int'(r[3:0]);
         if (ok && idx + k == 2) m_ctl = int'(r);
      end
      @(posedge ref_clk);
      #5;
      host.write_frame(q, acks);
      check("acks", 8'(acks), ok ? 8'(n + 2) : 8'h00);
      // Index 3 holds no register, so a frame aimed only there loads nothing
      m_loads = m_loads + int'(ok && n > 0 && idx < 3);
      m_pump = (ok && n > 0 && idx < 3) ? 0 : m_pump;
      tick(6);
      check("loads", 8'(loads), 8'(m_loads));
      compare_all();
   endtask : wr

   task pulse_drop;
      dropout = 1'b1;
      tick(5);
      dropout = 1'b0;
      tick(6);
      m_pump = (m_pump == 0) ? 1 : 2;
      compare_all();
   endtask : pulse_drop

   initial
   begin
      good = {led_ctrl_pkg::DEV_ADDR, 1'b0};
      r = 8'($urandom(32'h0000_08bf));
      tick(3);
      rst_n = 1'b1;
      tick(4);
      compare_all();
      $display("test reset done");
      for (int i = 0; i < 6; i++)
         wr(good, i % 3, 3 - i % 3, i == 0);
      wr(good, 2, 1, 1'b1);
      wr(good, 0, 2, 1'b0);
      $display("test frames done");
      cam_sel = 1'b1;
      tick(8);
      compare_all();
      repeat (3) pulse_drop();
      cam_sel = 1'b0;
      m_pump = 0;
      tick(8);
      compare_all();
      pulse_drop();
      wr(good, 0, 1, 1'b0);
      $display("test pump done");
      wr({led_ctrl_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 0, 1, 1'b0);
      wr({led_ctrl_pkg::DEV_ADDR, 1'b1}, 0, 1, 1'b0);
      wr(good, 0, 0, 1'b0);
      wr(good, 3, 1, 1'b0);
      $display("test refusal done");
      supply_ok = 1'b0;
      tick(10);
      {m_main, m_hi, m_lo, m_ctl, m_pump} = '0;
      compare_all();
      supply_ok = 1'b1;
      tick(4);
      wr(good, 0, 3, 1'b0);
      $display("test supply done");
      end_of_test();
   end
endmodule : led_brightness_control_regs_test
